// [logic/qcc_pkg.sv]
/*
 * qcc_pkg: constants, timing counts, register map and phase type of the quad cell charge sequencer.
 * assumes a single 25 MHz clock; all times are derived from it here.
 */
package qcc_pkg;
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned NCELL       = 4;
  localparam int unsigned MV_W        = 12;
  // timebase: one tick of 0.16 s, a slot is three ticks
  localparam int unsigned BLINK_MS    = 160;
  localparam int unsigned SLOT_MS     = 480;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned SLOT_TICKS  = SLOT_MS / BLINK_MS;
  localparam logic [2:0]  BLINK_PH    = 3'h6;
  localparam logic [2:0]  LONG_ON_PH  = 3'h5;
  localparam logic [2:0]  MID_ON_PH   = 3'h3;
  // long periods counted in slots
  localparam int unsigned HOLDOFF_MIN = 4;
  localparam int unsigned FLAT_MIN    = 16;
  localparam int unsigned HALF_HR_MIN = 30;
  localparam int unsigned HOLDOFF_SLOTS = HOLDOFF_MIN * 60_000 / SLOT_MS;
  localparam int unsigned FLAT_SLOTS    = FLAT_MIN * 60_000 / SLOT_MS;
  localparam int unsigned HALF_HR_SLOTS = HALF_HR_MIN * 60_000 / SLOT_MS;
  localparam int unsigned CNT_W       = 11;
  localparam int unsigned TMR_W       = 17;
  // fast charge timeout in half hours, 0.5 h to 10 h
  localparam logic [4:0]  TO_MIN      = 5'h01;
  localparam logic [4:0]  TO_MAX      = 5'h14;
  localparam logic [4:0]  TO_RST      = 5'h04;
  // voltage limits in mV
  localparam logic [11:0] LOW_CELL_MV    = 12'h3e8;
  localparam logic [11:0] OPEN_LIMIT_MV  = 12'h672;
  localparam logic [11:0] LOADED_LIM_MV  = 12'h6d6;
  localparam logic [11:0] NEG_DELTA_MV   = 12'h002;
  localparam logic [11:0] IMP_MIN_MV     = 12'h020;
  localparam logic [11:0] IMP_MAX_MV     = 12'h190;
  localparam logic [11:0] IMP_RST_MV     = 12'h064;
  // register map
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_IMP     = 8'h04;
  localparam logic [7:0]  REG_STAT    = 8'h08;
  localparam int unsigned CTRL_SUSP   = 0;
  localparam int unsigned CTRL_STYLE  = 1;
  localparam int unsigned CTRL_TO     = 8;
  localparam int unsigned STAT_SUSP   = 16;
  localparam logic [1:0]  STYLE_LOW   = 2'h0;
  localparam logic [1:0]  STYLE_FLOAT = 2'h1;
  localparam logic [1:0]  STYLE_HIGH  = 2'h2;
  localparam logic [1:0]  STYLE_RST   = 2'h0;

  typedef enum logic [2:0] {
    PH_PRESENCE, PH_QUALIFY, PH_PRE, PH_FAST, PH_TOPOFF, PH_MAINT, PH_FAULT
  } qcc_phase_e;
endpackage

// [logic/qcc_tb_if.sv]
/*
 * qcc_tb_if: timebase strobes passed from the divider to the sequencer.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface qcc_tb_if;
  logic       tick;
  logic       slot_stb;
  logic [1:0] slot_idx;
  logic [2:0] blink_ph;
  modport src (output tick, output slot_stb, output slot_idx, output blink_ph);
  modport snk (input tick, input slot_stb, input slot_idx, input blink_ph);
endinterface

// [logic/qcc_timebase.sv]
/*
 * qcc_timebase: divides the clock into 0.16 s ticks, 0.48 s slots rotating over four cells,
 * and a six-tick blink phase.
 * assumes a synchronous active-high reset; never paused by suspend so slot timing stays put.
 */
`timescale 1ns/1ps
module qcc_timebase #(
  parameter int unsigned TICK_CYCLES = qcc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // strobes
  qcc_tb_if.src     tb
);
  import qcc_pkg::*;

  localparam int unsigned DW = $clog2(TICK_CYCLES + 1);

  logic [DW-1:0] div_ff;
  logic [1:0]    tick_cnt_ff;
  logic          tick_ff;
  logic          stb_ff;
  logic [1:0]    idx_ff;
  logic [2:0]    ph_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == DW'(TICK_CYCLES - 1)) begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // slot strobe marks the last cycle of a slot; index moves one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 2'h0;
      stb_ff      <= 1'b0;
    end else begin
      stb_ff <= 1'b0;
      if (tick_ff) begin
        if (tick_cnt_ff == 2'(SLOT_TICKS - 1)) begin
          tick_cnt_ff <= 2'h0;
          stb_ff      <= 1'b1;
        end else begin
          tick_cnt_ff <= tick_cnt_ff + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_ff <= 2'h0;
    end else if (stb_ff) begin
      idx_ff <= idx_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_ff <= 3'h0;
    end else if (tick_ff) begin
      ph_ff <= (ph_ff == BLINK_PH - 3'h1) ? 3'h0 : ph_ff + 3'h1;
    end
  end

  assign tb.tick     = tick_ff;
  assign tb.slot_stb = stb_ff;
  assign tb.slot_idx = idx_ff;
  assign tb.blink_ph = ph_ff;
endmodule // qcc_timebase

// [logic/qcc_charger.sv]
/*
 * qcc_charger: four-slot cell charge sequencer with wishbone classic register slave.
 * assumes cell voltages arrive as mV codes from an outside converter, temperature as two
 * comparator levels per thermistor; all pins are asynchronous and pass two flip-flops.
 */
// What this block does
// - restart timer on fast/top-off entry; expiry moves fast
// - fast timeout 0.5-10 h; top-off half
// - top-off timer expiry enters maintenance
// - suspend floats switches, resets states and timers
// - fast charge starts only inside temperature window
// - stop temperature in fast enters maintenance
// - stop temperature in pre-charge enters fault
// - wait until resting voltage below open-circuit limit
// - low-cell threshold picks and ends pre-charge
// - loaded voltage checked every driven rotation in fast
// - loaded or resting overvoltage gives fault
// - loaded minus resting above impedance limit faults
// - after hold-off, resting sample every 16th own slot
// - keep maximum; 2 mV drop ends fast
// - maximum unchanged 16 minutes moves to top-off
// - pre-charge and top-off pulse one slot in four
// - maintenance pulses one slot in thirty-two
// - maintenance left only on removal, power, suspend
// - fast charge skips every 16th own slot
// - each cell sequences independently of others
// - indicator follows own cell, low or released
// - style select picks one of three blink tables
// - slots of 0.48 s, rotation 1.92 s
// - removal resets only that cell to presence
`timescale 1ns/1ps
module qcc_charger #(
  parameter int unsigned TICK_CYCLES = qcc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic                                       clk_i,
  input  wire logic                                       rst_i,
  // wishbone classic slave
  input  wire logic                                       wb_cyc_i,
  input  wire logic                                       wb_stb_i,
  input  wire logic                                       wb_we_i,
  input  wire logic [7:0]                                 wb_adr_i,
  input  wire logic [3:0]                                 wb_sel_i,
  input  wire logic [31:0]                                wb_dat_i,
  output logic      [31:0]                                wb_dat_o,
  output logic                                            wb_ack_o,
  // cell sense and temperature
  input  wire logic [qcc_pkg::NCELL-1:0]                  cell_present_i,
  input  wire logic [qcc_pkg::NCELL*qcc_pkg::MV_W-1:0]    cell_sense_input_i,
  input  wire logic [1:0]                                 temperature_ok_i,
  input  wire logic [1:0]                                 temperature_stop_i,
  // open-drain pins, enable low while pulling low
  output logic      [qcc_pkg::NCELL-1:0]                  charge_switch_n_o,
  output logic      [qcc_pkg::NCELL-1:0]                  charge_switch_n_oe_n_o,
  output logic      [qcc_pkg::NCELL-1:0]                  status_indicator_n_o,
  output logic      [qcc_pkg::NCELL-1:0]                  status_indicator_n_oe_n_o
);
  import qcc_pkg::*;

  function automatic logic [TMR_W-1:0] timer_limit(input logic [4:0] to, input logic topoff);
    logic [TMR_W-1:0] full;
    full = TMR_W'(to) * TMR_W'(HALF_HR_SLOTS);
    return topoff ? (full >> 1) : full;
  endfunction

  function automatic logic pulse_ok(input qcc_phase_e ph, input logic [4:0] cnt);
    case (ph)
      PH_FAST:           return cnt[3:0] != 4'hf;
      PH_PRE, PH_TOPOFF: return cnt[1:0] == 2'h0;
      PH_MAINT:          return cnt == 5'h00;
      default:           return 1'b0;
    endcase
  endfunction

  qcc_tb_if tb ();

  qcc_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tb    (tb.src)
  );

  // pin synchronisers
  logic [NCELL-1:0]       pres_m_ff, pres_s_ff;
  logic [NCELL*MV_W-1:0]  mv_m_ff, mv_s_ff;
  logic [1:0]             tok_m_ff, tok_s_ff, tstop_m_ff, tstop_s_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {pres_m_ff, mv_m_ff, tok_m_ff, tstop_m_ff} <= '0;
      {pres_s_ff, mv_s_ff, tok_s_ff, tstop_s_ff} <= '0;
    end else begin
      {pres_m_ff, mv_m_ff, tok_m_ff, tstop_m_ff} <= {cell_present_i, cell_sense_input_i,
                                                     temperature_ok_i, temperature_stop_i};
      {pres_s_ff, mv_s_ff, tok_s_ff, tstop_s_ff} <= {pres_m_ff, mv_m_ff, tok_m_ff, tstop_m_ff};
    end
  end

  // registers
  logic        susp_ff;
  logic [1:0]  style_ff;
  logic [4:0]  to_ff;
  logic [11:0] imp_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        wr_now;
  logic [4:0]  wr_to;
  logic [11:0] wr_imp;

  qcc_phase_e             phase_ff [NCELL];
  qcc_phase_e             nxt_phase [NCELL];
  logic [NCELL-1:0]       restart;
  logic [4:0]             own_cnt_ff [NCELL];
  logic [TMR_W-1:0]       tmr_ff [NCELL];
  logic [CNT_W-1:0]       hold_ff [NCELL];
  logic [CNT_W-1:0]       flat_ff [NCELL];
  logic [11:0]            vmax_ff [NCELL];
  logic [11:0]            von_ff [NCELL];
  logic [NCELL-1:0]       own_end;
  logic [NCELL-1:0]       new_max;

  assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign wr_to  = wb_dat_i[CTRL_TO +: 5];
  assign wr_imp = wb_dat_i[11:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      susp_ff  <= 1'b0;
      style_ff <= STYLE_RST;
      to_ff    <= TO_RST;
    end else if (wr_now && wb_adr_i == REG_CTRL) begin
      if (wb_sel_i[0]) begin
        susp_ff  <= wb_dat_i[CTRL_SUSP];
        style_ff <= (wb_dat_i[CTRL_STYLE +: 2] > STYLE_HIGH) ? STYLE_HIGH : wb_dat_i[CTRL_STYLE +: 2];
      end
      if (wb_sel_i[1]) begin
        to_ff <= (wr_to < TO_MIN) ? TO_MIN : (wr_to > TO_MAX) ? TO_MAX : wr_to;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imp_ff <= IMP_RST_MV;
    end else if (wr_now && wb_adr_i == REG_IMP && wb_sel_i[1:0] == 2'h3) begin
      imp_ff <= (wr_imp < IMP_MIN_MV) ? IMP_MIN_MV : (wr_imp > IMP_MAX_MV) ? IMP_MAX_MV : wr_imp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      case (wb_adr_i)
        REG_CTRL: dat_ff <= {19'h0, to_ff, 5'h00, style_ff, susp_ff};
        REG_IMP:  dat_ff <= {20'h0, imp_ff};
        REG_STAT: dat_ff <= {15'h0, susp_ff, 4'h0, phase_ff[3], phase_ff[2], phase_ff[1], phase_ff[0]};
        default:  dat_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // per-cell phase decisions
  always_comb begin
    logic [11:0] v;
    logic        tok;
    logic        tstop;
    logic        expired;
    v       = 12'h000;
    tok     = 1'b0;
    tstop   = 1'b0;
    expired = 1'b0;
    for (int c = 0; c < NCELL; c++) begin
      v            = mv_s_ff[c*MV_W +: MV_W];
      tok          = tok_s_ff[c/2];
      tstop        = tstop_s_ff[c/2];
      own_end[c]   = tb.slot_stb && (tb.slot_idx == 2'(c));
      expired      = tmr_ff[c] >= timer_limit(to_ff, phase_ff[c] == PH_TOPOFF);
      nxt_phase[c] = phase_ff[c];
      restart[c]   = 1'b0;
      new_max[c]   = 1'b0;
      case (phase_ff[c])
        PH_PRESENCE: begin
          if (pres_s_ff[c]) begin
            nxt_phase[c] = PH_QUALIFY;
          end
        end
        PH_QUALIFY: begin
          if (v < OPEN_LIMIT_MV) begin
            if (v < LOW_CELL_MV) begin
              nxt_phase[c] = PH_PRE;
            end else if (tok) begin
              nxt_phase[c] = PH_FAST;
              restart[c]   = 1'b1;
            end
          end
        end
        PH_PRE: begin
          if (tstop) begin
            nxt_phase[c] = PH_FAULT;
          end else if (own_end[c] && v >= LOW_CELL_MV && tok) begin
            nxt_phase[c] = PH_FAST;
            restart[c]   = 1'b1;
          end
        end
        PH_FAST: begin
          if (tstop) begin
            nxt_phase[c] = PH_MAINT;
          end else if (expired) begin
            nxt_phase[c] = PH_TOPOFF;
            restart[c]   = 1'b1;
          end else if (flat_ff[c] >= CNT_W'(FLAT_SLOTS)) begin
            nxt_phase[c] = PH_TOPOFF;
            restart[c]   = 1'b1;
          end else if (own_end[c]) begin
            if (pulse_ok(phase_ff[c], own_cnt_ff[c])) begin
              if (v > LOADED_LIM_MV) begin
                nxt_phase[c] = PH_FAULT;
              end
            end else if (v > OPEN_LIMIT_MV) begin
              nxt_phase[c] = PH_FAULT;
            end else if (von_ff[c] > v && (von_ff[c] - v) > imp_ff) begin
              nxt_phase[c] = PH_FAULT;
            end else if (hold_ff[c] >= CNT_W'(HOLDOFF_SLOTS)) begin
              if (v > vmax_ff[c]) begin
                new_max[c] = 1'b1;
              end else if (vmax_ff[c] - v >= NEG_DELTA_MV) begin
                nxt_phase[c] = PH_TOPOFF;
                restart[c]   = 1'b1;
              end
            end
          end
        end
        PH_TOPOFF: begin
          if (expired) begin
            nxt_phase[c] = PH_MAINT;
          end
        end
        PH_MAINT: nxt_phase[c] = PH_MAINT;
        PH_FAULT: nxt_phase[c] = PH_FAULT;
        default:  nxt_phase[c] = PH_PRESENCE;
      endcase
      if (!pres_s_ff[c] || susp_ff) begin
        nxt_phase[c] = PH_PRESENCE;
        restart[c]   = 1'b0;
        new_max[c]   = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCELL; c++) begin
      if (rst_i) begin
        phase_ff[c] <= PH_PRESENCE;
      end else begin
        phase_ff[c] <= nxt_phase[c];
      end
    end
  end

  // own-slot counter drives duty ratios
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCELL; c++) begin
      if (rst_i || phase_ff[c] == PH_PRESENCE) begin
        own_cnt_ff[c] <= 5'h00;
      end else if (own_end[c]) begin
        own_cnt_ff[c] <= own_cnt_ff[c] + 5'h01;
      end
    end
  end

  // charge timer counts slots in fast and top-off, frozen and cleared in suspend
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCELL; c++) begin
      if (rst_i || restart[c] || susp_ff) begin
        tmr_ff[c] <= '0;
      end else if (tb.slot_stb && (phase_ff[c] == PH_FAST || phase_ff[c] == PH_TOPOFF)
                   && tmr_ff[c] != '1) begin
        tmr_ff[c] <= tmr_ff[c] + 1'b1;
      end
    end
  end

  // hold-off and flat counters, stored maximum and last loaded voltage
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCELL; c++) begin
      if (rst_i || phase_ff[c] != PH_FAST) begin
        hold_ff[c] <= '0;
        flat_ff[c] <= '0;
        vmax_ff[c] <= 12'h000;
      end else if (new_max[c]) begin
        vmax_ff[c] <= mv_s_ff[c*MV_W +: MV_W];
        flat_ff[c] <= '0;
      end else if (tb.slot_stb) begin
        if (hold_ff[c] < CNT_W'(HOLDOFF_SLOTS)) begin
          hold_ff[c] <= hold_ff[c] + 1'b1;
        end else if (flat_ff[c] < CNT_W'(FLAT_SLOTS)) begin
          flat_ff[c] <= flat_ff[c] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCELL; c++) begin
      if (rst_i || phase_ff[c] == PH_PRESENCE) begin
        von_ff[c] <= 12'h000;
      end else if (own_end[c] && phase_ff[c] == PH_FAST && pulse_ok(phase_ff[c], own_cnt_ff[c])) begin
        von_ff[c] <= mv_s_ff[c*MV_W +: MV_W];
      end
    end
  end

  // charge switches: one cell per slot, duty by phase
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NCELL; c++) begin
      if (rst_i || susp_ff) begin
        charge_switch_n_o[c]      <= 1'b0;
        charge_switch_n_oe_n_o[c] <= 1'b1;
      end else begin
        charge_switch_n_oe_n_o[c] <= ~(tb.slot_idx == 2'(c) && !tb.slot_stb
                                       && pulse_ok(phase_ff[c], own_cnt_ff[c]));
      end
    end
  end

  // indicators
  logic [NCELL-1:0] ind_on;

  always_comb begin
    for (int c = 0; c < NCELL; c++) begin
      case (phase_ff[c])
        PH_PRE, PH_FAST, PH_TOPOFF: ind_on[c] = (style_ff == STYLE_HIGH) ? (tb.blink_ph < LONG_ON_PH) : 1'b1;
        PH_MAINT: ind_on[c] = (style_ff == STYLE_LOW) ? (tb.blink_ph < LONG_ON_PH) : (style_ff == STYLE_HIGH);
        PH_FAULT: ind_on[c] = (style_ff == STYLE_LOW) ? (tb.blink_ph < MID_ON_PH) : ~tb.blink_ph[0];
        default:  ind_on[c] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_indicator_n_o      <= '0;
      status_indicator_n_oe_n_o <= '1;
    end else begin
      status_indicator_n_oe_n_o <= ~ind_on;
    end
  end
endmodule // qcc_charger

// [dv/qcc_charger_chk.sv]
/*
 * qcc_charger_chk: port-level assertions for the charge sequencer.
 * assumes only the top module's ports; bound to every qcc_charger below.
 */
`timescale 1ns/1ps
module qcc_charger_chk #(
  parameter int unsigned TICK_CYCLES = qcc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  // bus
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  // pins
  input wire logic [qcc_pkg::NCELL-1:0]  charge_switch_n_o,
  input wire logic [qcc_pkg::NCELL-1:0]  charge_switch_n_oe_n_o,
  input wire logic [qcc_pkg::NCELL-1:0]  status_indicator_n_o,
  input wire logic [qcc_pkg::NCELL-1:0]  status_indicator_n_oe_n_o
);
  import qcc_pkg::*;
  logic [31:0] on_cnt_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // length of the current unbroken switch-on run
  always_ff @(posedge clk_i) begin
    if (rst_i || &charge_switch_n_oe_n_o) begin
      on_cnt_ff <= 32'h0;
    end else begin
      on_cnt_ff <= on_cnt_ff + 32'h1;
    end
  end

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack wider than one cycle");
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not after one wait");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_rdata_held: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o)) else $error("read data moved");
  a_drive_low_only: assert property (charge_switch_n_o == '0 && status_indicator_n_o == '0)
    else $error("open-drain data not low");
  a_one_cell_on: assert property ($onehot0(~charge_switch_n_oe_n_o)) else $error("two switches on");
  a_pulse_length: assert property (on_cnt_ff <= 32'(3 * TICK_CYCLES - 1)) else $error("pulse longer than slot");
  a_no_handover: assert property (!(&charge_switch_n_oe_n_o) && !(&$past(charge_switch_n_oe_n_o))
    |-> $stable(charge_switch_n_oe_n_o)) else $error("switch handed over without gap");
  a_reset_idle: assert property ($fell(rst_i) |-> &charge_switch_n_oe_n_o && &status_indicator_n_oe_n_o && !wb_ack_o)
    else $error("pins not released after reset");
endmodule // qcc_charger_chk

bind qcc_charger qcc_charger_chk #(.TICK_CYCLES(TICK_CYCLES)) u_qcc_charger_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .charge_switch_n_o(charge_switch_n_o), .charge_switch_n_oe_n_o(charge_switch_n_oe_n_o),
  .status_indicator_n_o(status_indicator_n_o), .status_indicator_n_oe_n_o(status_indicator_n_oe_n_o)
);

// [dv/qcc_cell_model.sv]
/*
 * qcc_cell_model: four cells behind pass switches; sense shows resting voltage plus a loaded rise.
 * assumes switch pins already resolved with their pull-ups.
 */
`timescale 1ns/1ps
module qcc_cell_model (
  // clock
  input  wire logic        clk_i,
  // switch pins and cell settings
  input  wire logic [3:0]  switch_n_i,
  input  wire logic [47:0] rest_mv_i,
  input  wire logic [47:0] bump_mv_i,
  // sense
  output logic      [47:0] sense_o
);
  // loaded voltage only while the pin is pulled low
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 4; c++) begin
      sense_o[c*12 +: 12] <= rest_mv_i[c*12 +: 12] + (switch_n_i[c] ? 12'h000 : bump_mv_i[c*12 +: 12]);
    end
  end
endmodule // qcc_cell_model

// [dv/qcc_charger_bench.sv]
/*
 * qcc_charger_bench: register and charge sequence tests for the charge sequencer.
 * assumes the cell model on the switch pins and a shortened tick.
 */
`timescale 1ns/1ps
module qcc_charger_bench;
  import qcc_pkg::*;
  localparam int unsigned TICK = 4;
  localparam int unsigned SLOT = 3 * TICK;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [31:0] wb_dat_i  = 32'h0;
  logic [3:0]  wb_sel_i  = 4'hf;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  present   = 4'h0;
  logic [1:0]  temp_ok   = 2'h3;
  logic [1:0]  temp_stop = 2'h0;
  logic [47:0] rest_mv   = '0;
  logic [47:0] bump_mv   = '0;
  logic [47:0] sense;
  logic [3:0]  sw_n;
  logic [3:0]  sw_oe_n;
  logic [3:0]  ind_n;
  logic [3:0]  ind_oe_n;
  wire  [3:0]  sw_pin    = sw_oe_n | sw_n;
  int          mismatches   = 0;
  int          total_checks = 0;
  int          lows [4];
  logic [31:0] rd;

  always #20 clk_i = ~clk_i;

  qcc_charger #(.TICK_CYCLES(TICK)) u_qcc_charger (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cell_present_i(present), .cell_sense_input_i(sense), .temperature_ok_i(temp_ok),
    .temperature_stop_i(temp_stop), .charge_switch_n_o(sw_n), .charge_switch_n_oe_n_o(sw_oe_n),
    .status_indicator_n_o(ind_n), .status_indicator_n_oe_n_o(ind_oe_n)
  );
  qcc_cell_model u_qcc_cell_model (
    .clk_i(clk_i), .switch_n_i(sw_pin), .rest_mv_i(rest_mv), .bump_mv_i(bump_mv), .sense_o(sense)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, entered just after a rising edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel = 4'hf);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    check("bus wait", 32'(n), 32'h2);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    check(what, rd, exp);
  endtask

  function automatic logic [31:0] st(input qcc_phase_e a, input qcc_phase_e b, input qcc_phase_e c,
                                     input qcc_phase_e d);
    return {20'h0, d, c, b, a};
  endfunction

  task automatic set_cell(input int c, input logic [11:0] r, input logic [11:0] b);
    rest_mv[c*12 +: 12] <= r;
    bump_mv[c*12 +: 12] <= b;
  endtask

  task automatic wait_slots(input int n);
    repeat (n * SLOT) @(posedge clk_i);
  endtask

  // low cycles per cell on switch pins or indicators
  task automatic count_low(input int n, input bit ind);
    lows = '{default: 0};
    repeat (n) begin
      @(posedge clk_i);
      for (int c = 0; c < 4; c++) lows[c] += int'(ind ? !ind_oe_n[c] : !sw_pin[c]);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("ctrl", REG_CTRL, 32'h0000_0400);
    rd_chk("imp", REG_IMP, 32'h0000_0064);
    rd_chk("stat", REG_STAT, 32'h0);
    rd_chk("unmapped", 8'h0c, 32'h0);
    xfer(1'b1, REG_CTRL, 32'h0000_1f00);
    rd_chk("ctrl", REG_CTRL, 32'h0000_1400);
    xfer(1'b1, REG_CTRL, 32'h0000_0000);
    rd_chk("ctrl", REG_CTRL, 32'h0000_0100);
    xfer(1'b1, REG_STAT, 32'hffff_ffff);
    rd_chk("stat", REG_STAT, 32'h0);
    xfer(1'b1, REG_CTRL, 32'h0000_0400);
    set_cell(0, 12'h4b0, 12'h032);
    set_cell(1, 12'h384, 12'h032);
    set_cell(2, 12'h6a4, 12'h032);
    set_cell(3, 12'h4b0, 12'h032);
    present <= 4'hf;
    wait_slots(8);
    rd_chk("stat", REG_STAT, st(PH_FAST, PH_PRE, PH_QUALIFY, PH_FAST));
    set_cell(3, 12'h4b0, 12'h12c);
    wait_slots(70);
    rd_chk("stat", REG_STAT, st(PH_FAST, PH_PRE, PH_QUALIFY, PH_FAULT));
    temp_ok   <= 2'h2;
    temp_stop <= 2'h1;
    wait_slots(1);
    temp_ok   <= 2'h3;
    temp_stop <= 2'h0;
    rd_chk("stat", REG_STAT, st(PH_MAINT, PH_FAULT, PH_QUALIFY, PH_FAULT));
    xfer(1'b1, REG_CTRL, 32'h0000_0402);
    count_low(6 * TICK, 1'b1);
    check("ind maint", 32'(lows[0]), 32'h0);
    check("ind fault", 32'(lows[1]), 32'(3 * TICK));
    xfer(1'b1, REG_CTRL, 32'h0000_0404);
    count_low(6 * TICK, 1'b1);
    check("ind maint high", 32'(lows[0]), 32'(6 * TICK));
    check("ind fault high", 32'(lows[1]), 32'(3 * TICK));
    xfer(1'b1, REG_CTRL, 32'h0000_0400);
    count_low(6 * TICK, 1'b1);
    check("ind maint low", 32'(lows[0]), 32'(5 * TICK));
    check("ind fault low", 32'(lows[1]), 32'(3 * TICK));
    present <= 4'hd;
    wait_slots(1);
    rd_chk("stat", REG_STAT, st(PH_MAINT, PH_PRESENCE, PH_QUALIFY, PH_FAULT));
    present <= 4'hf;
    xfer(1'b1, REG_IMP, 32'h0000_01ff);
    rd_chk("imp", REG_IMP, 32'h0000_0190);
    xfer(1'b1, REG_IMP, 32'h0000_0020, 4'h1);
    rd_chk("imp", REG_IMP, 32'h0000_0190);
    xfer(1'b1, REG_CTRL, 32'h0000_0101);
    rd_chk("stat", REG_STAT, 32'h0001_0000);
    count_low(4 * SLOT, 1'b0);
    check("suspend pins", 32'(lows[0] + lows[1] + lows[2] + lows[3]), 32'h0);
    set_cell(3, 12'h578, 12'h190);
    xfer(1'b1, REG_CTRL, 32'h0000_0100);
    wait_slots(8);
    rd_chk("stat", REG_STAT, st(PH_FAST, PH_PRE, PH_QUALIFY, PH_FAULT));
    count_low(64 * SLOT, 1'b0);
    check("fast pulses", 32'(lows[0]), 32'(15 * (SLOT - 1)));
    check("pre pulses", 32'(lows[1]), 32'(4 * (SLOT - 1)));
    check("held pulses", 32'(lows[2] + lows[3]), 32'h0);
    wait_slots(2600);
    rd_chk("stat", REG_STAT, st(PH_TOPOFF, PH_PRE, PH_QUALIFY, PH_FAULT));
    wait_slots(2000);
    rd_chk("stat", REG_STAT, st(PH_MAINT, PH_PRE, PH_QUALIFY, PH_FAULT));
    count_low(128 * SLOT, 1'b0);
    check("maint pulses", 32'(lows[0]), 32'(SLOT - 1));
    close_out();
  end
endmodule // qcc_charger_bench
